// ==== core/tipu_pkg.sv ====
// Package: constants and types for the task isolation protection unit
package tipu_pkg;

	// ==========================================================
	// Widths and table sizes
	localparam int ADDR_W      = 32;
	localparam int PAGE_SHIFT  = 12;                 // 4KB pages
	localparam int PAGE_W      = ADDR_W - PAGE_SHIFT;
	localparam int NUM_REGIONS = 8;
	localparam int REG_IDX_W   = 3;
	localparam int NUM_LINKS   = 4;
	localparam int LINK_W      = 2;
	localparam int NUM_STACKS  = 4;
	localparam int STACK_W     = 2;
	localparam int NUM_ZONES   = 2;
	localparam int ZONE_W      = 1;
	localparam int PWD_W       = 32;

	// ==========================================================
	// Reset values
	localparam logic [LINK_W-1:0]  RST_LINK  = 2'h0;
	localparam logic [ADDR_W-1:0]  RST_SP    = 32'h0;
	localparam logic [STACK_W-1:0] RST_STACK = 2'h0;
	localparam logic [ZONE_W-1:0]  RST_ZONE  = 1'h0;

	// ==========================================================
	// Instruction classes reported by the core
	typedef enum logic [3:0] {
		OP_PLAIN   = 4'h0,
		OP_CALL    = 4'h1,
		OP_RET     = 4'h2,
		OP_PCALL   = 4'h3,
		OP_PRET    = 4'h4,
		OP_PBRANCH = 4'h5,
		OP_ENTRY1  = 4'h6,
		OP_ENTRY2  = 4'h7,
		OP_EXIT    = 4'h8
	} tipu_op_t;

	// Configuration targets
	typedef enum logic [1:0] {
		CFG_REGION = 2'h0,
		CFG_LINK   = 2'h1,
		CFG_STACK  = 2'h2,
		CFG_SP     = 2'h3
	} tipu_cfg_kind_t;

	// Checker states, one-hot
	typedef enum logic [4:0] {
		ST_RUN   = 5'h01,
		ST_E1    = 5'h02,
		ST_E2    = 5'h04,
		ST_EXIT  = 5'h08,
		ST_FAULT = 5'h10
	} tipu_state_t;

	typedef struct packed {
		logic                 valid;
		logic [PAGE_W-1:0]    start_pg;
		logic [PAGE_W-1:0]    end_pg;
		logic [LINK_W-1:0]    owner;
		logic [NUM_LINKS-1:0] rd;
		logic [NUM_LINKS-1:0] wr;
	} tipu_region_t;

	typedef struct packed {
		tipu_cfg_kind_t       kind;
		logic [REG_IDX_W-1:0] idx;
		tipu_region_t         region;
		logic [STACK_W-1:0]   stack;
		logic [ZONE_W-1:0]    zone;
		logic [ADDR_W-1:0]    sp;
	} tipu_cfg_t;

	typedef struct packed {
		tipu_op_t          op;
		logic [ADDR_W-1:0] pc;
		logic [ADDR_W-1:0] target;
	} tipu_ins_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              write;
	} tipu_da_t;

endpackage

// ==== core/tipu_top.sv ====
// Task isolation protection unit: access, transfer and stack checks
// What this block does
// (R1) Every core access is checked; each resource must lie in a region.
// (R2) Executing code takes its link from its region; link to stack to zone.
// (R3) Ordinary call and return may change link only within one stack.
// (R4) Protected call and return may cross stacks; no stack check applies to them.
// (R5) Protected branch gets exactly the protected call checks.
// (R6) Links, stacks, regions are per core; zone passwords are chip-wide.
// (R7) Entering a task loads its saved secure stack pointer into the core.
// (R8) Leaving a task saves the core stack pointer into its secure copy.
// (R9) Tasks reach others' memory or peripherals only where regions grant.
// (R10) Zone debug access refused until a matching zone password is given.
// (R11) Region bounds compare at 4KB pages, ignoring lower address bits.
// (R12) Per link per region read and write permission gate every data access.
// (R13) Protected call may enter code of a different stack.
// (R14) Protected call target must run both entry markers first, else fault.
// (R15) Protected return address must run the exit marker first, else fault.
`timescale 1ns/1ps
`default_nettype none

module tipu_top
	import tipu_pkg::*;
(
	input  wire logic                                      clk,
	input  wire logic                                      sys_rst,
	input  wire logic                                      ce,
	input  wire logic                                      cfg_valid,
	input  wire tipu_pkg::tipu_cfg_t                       cfg,
	input  wire logic                                      ins_valid,
	input  wire tipu_pkg::tipu_ins_t                       ins,
	input  wire logic [tipu_pkg::ADDR_W-1:0]               sp_in,
	output logic                                           sp_load_valid,
	output logic [tipu_pkg::ADDR_W-1:0]                    sp_load_value,
	input  wire logic                                      da_valid,
	input  wire tipu_pkg::tipu_da_t                        da,
	output logic                                           da_done,
	output logic                                           da_ok,
	input  wire logic                                      dbg_unlock_req,
	input  wire logic [tipu_pkg::ZONE_W-1:0]               dbg_unlock_zone,
	input  wire logic [tipu_pkg::PWD_W-1:0]                dbg_unlock_pwd,
	input  wire logic [tipu_pkg::NUM_ZONES-1:0][tipu_pkg::PWD_W-1:0] zone_pwd,
	output logic                                           dbg_unlock_done,
	output logic                                           dbg_unlock_ok,
	input  wire logic                                      dbg_acc_req,
	input  wire logic [tipu_pkg::ZONE_W-1:0]               dbg_acc_zone,
	output logic                                           dbg_acc_ok,
	output logic [tipu_pkg::LINK_W-1:0]                    cur_link,
	output logic                                           fault
);
	import tipu_pkg::*;

	// ==========================================================
	// Storage
	// Tables are local to this core; zone passwords arrive from a
	// chip-wide store, so several cores see one zone set.
	tipu_region_t        region_reg     [NUM_REGIONS]; // R6
	logic [STACK_W-1:0]  link_stack_reg [NUM_LINKS];
	logic [ZONE_W-1:0]   stack_zone_reg [NUM_STACKS];
	logic [ADDR_W-1:0]   saved_sp_reg   [NUM_LINKS];
	logic [LINK_W-1:0]   cur_link_reg;
	tipu_state_t         state_reg;
	tipu_state_t         state_next;
	logic                sp_load_valid_reg;
	logic [ADDR_W-1:0]   sp_load_value_reg;
	logic                da_done_reg;
	logic                da_ok_reg;
	logic [NUM_ZONES-1:0] zone_dbg_en_reg;
	logic                dbg_unlock_done_reg;
	logic                dbg_unlock_ok_reg;

	// ==========================================================
	// Decode helpers
	// Page compare only: bits below 4KB never reach the comparators
	function automatic logic in_region(input tipu_region_t r,
		input logic [PAGE_W-1:0] pg);
		in_region = r.valid && (pg >= r.start_pg) && (pg <= r.end_pg); // R11
	endfunction

	// Lowest-numbered hit region decides the owning link
	function automatic logic [LINK_W-1:0] owner_of(
		input logic [NUM_REGIONS-1:0] hit,
		input logic [NUM_REGIONS-1:0][LINK_W-1:0] own);
		owner_of = RST_LINK;
		for (int i = NUM_REGIONS - 1; i >= 0; i--) begin
			if (hit[i]) begin
				owner_of = own[i];
			end
		end
	endfunction

	wire [PAGE_W-1:0] tgt_pg = ins.target[ADDR_W-1:PAGE_SHIFT];
	wire [PAGE_W-1:0] pc_pg  = ins.pc[ADDR_W-1:PAGE_SHIFT];
	wire [PAGE_W-1:0] da_pg  = da.addr[ADDR_W-1:PAGE_SHIFT];

	logic [NUM_REGIONS-1:0]             tgt_hit;
	logic [NUM_REGIONS-1:0]             pc_hit;
	logic [NUM_REGIONS-1:0]             rd_hit;
	logic [NUM_REGIONS-1:0]             wr_hit;
	logic [NUM_REGIONS-1:0][LINK_W-1:0] owners;

	// Per-region match and permission terms
	for (genvar g = 0; g < NUM_REGIONS; g++) begin : g_region
		assign tgt_hit[g] = in_region(region_reg[g], tgt_pg);
		assign pc_hit[g]  = in_region(region_reg[g], pc_pg);
		assign rd_hit[g]  = in_region(region_reg[g], da_pg)
			&& region_reg[g].rd[cur_link_reg]; // R12
		assign wr_hit[g]  = in_region(region_reg[g], da_pg)
			&& region_reg[g].wr[cur_link_reg]; // R12
		assign owners[g]  = region_reg[g].owner;
	end

	// ==========================================================
	// Transfer classification
	wire [LINK_W-1:0] tgt_link  = owner_of(tgt_hit, owners); // R2
	wire [LINK_W-1:0] pc_link   = owner_of(pc_hit, owners);
	wire              tgt_found = |tgt_hit; // R1
	wire              same_stack = link_stack_reg[tgt_link]
		== link_stack_reg[cur_link_reg];
	wire in_run   = state_reg == ST_RUN;
	wire op_plain = ins_valid && (ins.op == OP_CALL || ins.op == OP_RET);
	// Protected branch shares every check of the protected call
	wire op_pin   = ins_valid
		&& (ins.op == OP_PCALL || ins.op == OP_PBRANCH); // R5
	wire op_pout  = ins_valid && ins.op == OP_PRET;
	// Code fetched outside a region, or from another link's region
	wire pc_bad   = ins_valid && (!(|pc_hit) || pc_link != cur_link_reg); // R9
	wire plain_bad = op_plain && (!tgt_found || !same_stack); // R3
	wire prot_ok  = (op_pin || op_pout) && tgt_found;
	wire xfer_ok  = in_run && !pc_bad
		&& ((op_plain && !plain_bad) || prot_ok);
	wire sp_swap  = xfer_ok && prot_ok && tgt_link != cur_link_reg;
	wire [ADDR_W-1:0] tgt_sp = saved_sp_reg[tgt_link];

	// ==========================================================
	// Marker sequencer
	// Protected moves pass regardless of stack; only the markers, the fetch
	// check and the target region lookup can reject them.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN: begin
				if (pc_bad || plain_bad) begin
					state_next = ST_FAULT;
				end else if ((op_pin || op_pout) && !tgt_found) begin
					state_next = ST_FAULT; // R1
				end else if (op_pin) begin
					state_next = ST_E1; // R13
				end else if (op_pout) begin
					state_next = ST_EXIT; // R4
				end
			end
			ST_E1: begin
				if (ins_valid) begin
					state_next = (ins.op == OP_ENTRY1) ? ST_E2 : ST_FAULT; // R14
				end
			end
			ST_E2: begin
				if (ins_valid) begin
					state_next = (ins.op == OP_ENTRY2) ? ST_RUN : ST_FAULT; // R14
				end
			end
			ST_EXIT: begin
				if (ins_valid) begin
					state_next = (ins.op == OP_EXIT) ? ST_RUN : ST_FAULT; // R15
				end
			end
			ST_FAULT: begin
				state_next = ST_FAULT;
			end
			default: begin
				state_next = ST_FAULT;
			end
		endcase
	end

	// State and current link; fault holds until reset
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg    <= ST_RUN;
			cur_link_reg <= RST_LINK;
		end else if (ce) begin
			state_reg <= state_next;
			if (xfer_ok) begin
				cur_link_reg <= tgt_link; // R2
			end
		end
	end

	// ==========================================================
	// Configuration tables, loaded by trusted boot logic
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < NUM_REGIONS; i++) begin
				region_reg[i] <= '0;
			end
			for (int i = 0; i < NUM_LINKS; i++) begin
				link_stack_reg[i] <= RST_STACK;
			end
			for (int i = 0; i < NUM_STACKS; i++) begin
				stack_zone_reg[i] <= RST_ZONE;
			end
		end else if (ce && cfg_valid) begin
			if (cfg.kind == CFG_REGION) begin
				region_reg[cfg.idx] <= cfg.region;
			end else if (cfg.kind == CFG_LINK) begin
				link_stack_reg[cfg.idx[LINK_W-1:0]] <= cfg.stack; // R2
			end else if (cfg.kind == CFG_STACK) begin
				stack_zone_reg[cfg.idx[STACK_W-1:0]] <= cfg.zone; // R2
			end
		end
	end

	// ==========================================================
	// Secure stack pointers
	// A swap outranks any same-cycle CFG_SP config write, whichever link it names
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < NUM_LINKS; i++) begin
				saved_sp_reg[i] <= RST_SP;
			end
			sp_load_valid_reg <= 1'b0;
			sp_load_value_reg <= RST_SP;
		end else if (ce) begin
			sp_load_valid_reg <= sp_swap;
			if (sp_swap) begin
				sp_load_value_reg <= tgt_sp; // R7
				saved_sp_reg[cur_link_reg] <= sp_in; // R8
			end else if (cfg_valid && cfg.kind == CFG_SP) begin
				saved_sp_reg[cfg.idx[LINK_W-1:0]] <= cfg.sp;
			end
		end
	end

	// ==========================================================
	// Data access check, answered one cycle after the request
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			da_done_reg <= 1'b0;
			da_ok_reg   <= 1'b0;
		end else if (ce) begin
			da_done_reg <= da_valid;
			da_ok_reg   <= da_valid
				&& (da.write ? |wr_hit : |rd_hit); // R9
		end
	end

	// ==========================================================
	// Zone debug unlock
	// A wrong password leaves the zone as it was; only reset relocks
	wire unlock_match = dbg_unlock_pwd == zone_pwd[dbg_unlock_zone]; // R10
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			zone_dbg_en_reg     <= '0;
			dbg_unlock_done_reg <= 1'b0;
			dbg_unlock_ok_reg   <= 1'b0;
		end else if (ce) begin
			dbg_unlock_done_reg <= dbg_unlock_req;
			dbg_unlock_ok_reg   <= dbg_unlock_req && unlock_match;
			if (dbg_unlock_req && unlock_match) begin
				zone_dbg_en_reg[dbg_unlock_zone] <= 1'b1; // R10
			end
		end
	end

	// ==========================================================
	// Outputs
	assign dbg_acc_ok      = dbg_acc_req && zone_dbg_en_reg[dbg_acc_zone];
	assign sp_load_valid   = sp_load_valid_reg;
	assign sp_load_value   = sp_load_value_reg;
	assign da_done         = da_done_reg;
	assign da_ok           = da_ok_reg;
	assign dbg_unlock_done = dbg_unlock_done_reg;
	assign dbg_unlock_ok   = dbg_unlock_ok_reg;
	assign cur_link        = cur_link_reg;
	assign fault           = state_reg == ST_FAULT;

	// ==========================================================
	// Assertions
	property p_plain_cross;
		@(posedge clk) disable iff (sys_rst)
		ce && in_run && op_plain && tgt_found && !same_stack |=> fault;
	endproperty
	a_plain_cross: assert property (p_plain_cross) // R3
		else $error("ordinary call across stacks not faulted");

	property p_pcall_enter;
		@(posedge clk) disable iff (sys_rst)
		ce && in_run && !pc_bad && op_pin && tgt_found
		|=> state_reg == ST_E1 && cur_link == $past(tgt_link);
	endproperty
	a_pcall_enter: assert property (p_pcall_enter) // R13
		else $error("protected call did not enter target link");

	property p_entry_seq;
		@(posedge clk) disable iff (sys_rst)
		ce && state_reg == ST_E1 && ins_valid && ins.op != OP_ENTRY1
		|=> fault ##1 fault;
	endproperty
	a_entry_seq: assert property (p_entry_seq) // R14
		else $error("missing first entry marker not faulted");

	property p_exit_seq;
		@(posedge clk) disable iff (sys_rst)
		ce && state_reg == ST_EXIT && ins_valid && ins.op != OP_EXIT
		|=> fault;
	endproperty
	a_exit_seq: assert property (p_exit_seq) // R15
		else $error("missing exit marker not faulted");

	property p_sp_load;
		@(posedge clk) disable iff (sys_rst)
		ce && sp_swap |=> sp_load_valid && sp_load_value == $past(tgt_sp);
	endproperty
	a_sp_load: assert property (p_sp_load) // R7
		else $error("secure stack pointer not loaded on entry");

	property p_sp_save;
		@(posedge clk) disable iff (sys_rst)
		ce && sp_swap |=> saved_sp_reg[$past(cur_link_reg)] == $past(sp_in);
	endproperty
	a_sp_save: assert property (p_sp_save) // R8
		else $error("stack pointer not saved on exit");

	property p_write_deny;
		@(posedge clk) disable iff (sys_rst)
		ce && da_valid && da.write && !(|wr_hit) |=> da_done && !da_ok;
	endproperty
	a_write_deny: assert property (p_write_deny) // R12
		else $error("write granted without write permission");

	property p_bad_pwd;
		@(posedge clk) disable iff (sys_rst)
		ce && dbg_unlock_req && !unlock_match
		|=> $stable(zone_dbg_en_reg) && !dbg_unlock_ok;
	endproperty
	a_bad_pwd: assert property (p_bad_pwd) // R10
		else $error("zone unlocked by wrong password");

endmodule

`default_nettype wire

// ==== tb/test_tipu_top.sv ====
// Self-checking bench for the task isolation protection unit
`timescale 1ns/1ps
`default_nettype none
`define CK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end

module test_tipu_top;
	import tipu_pkg::*;
	logic clk = 0, sys_rst = 1, cfg_valid = 0, ins_valid = 0, da_valid = 0;
	logic dbg_unlock_req = 0, dbg_acc_req = 0, set_en = 0, ce = 1;
	logic sp_load_valid, da_done, da_ok, dbg_unlock_done, dbg_unlock_ok;
	logic dbg_acc_ok, fault;
	logic [ZONE_W-1:0] dbg_unlock_zone = 0, dbg_acc_zone = 0;
	logic [PWD_W-1:0] dbg_unlock_pwd = 0;
	logic [NUM_ZONES-1:0][PWD_W-1:0] zone_pwd = {32'hA5A5_0002, 32'h5A5A_0001};
	logic [ADDR_W-1:0] sp_in, sp_load_value, set_val = 0;
	logic [LINK_W-1:0] cur_link;
	tipu_cfg_t cfg = '0;
	tipu_ins_t ins = '0;
	tipu_da_t  da = '0;
	int errors = 0, n_checks = 0, cyc = 0;

	tipu_top tipu_top_i (.clk(clk), .sys_rst(sys_rst), .ce(ce),
		.cfg_valid(cfg_valid), .cfg(cfg), .ins_valid(ins_valid), .ins(ins),
		.sp_in(sp_in), .sp_load_valid(sp_load_valid),
		.sp_load_value(sp_load_value), .da_valid(da_valid), .da(da),
		.da_done(da_done), .da_ok(da_ok), .dbg_unlock_req(dbg_unlock_req),
		.dbg_unlock_zone(dbg_unlock_zone), .dbg_unlock_pwd(dbg_unlock_pwd),
		.zone_pwd(zone_pwd), .dbg_unlock_done(dbg_unlock_done),
		.dbg_unlock_ok(dbg_unlock_ok), .dbg_acc_req(dbg_acc_req),
		.dbg_acc_zone(dbg_acc_zone), .dbg_acc_ok(dbg_acc_ok),
		.cur_link(cur_link), .fault(fault));
	tipu_core_model tipu_core_model_i (.clk(clk), .sys_rst(sys_rst),
		.sp_load_valid(sp_load_valid), .sp_load_value(sp_load_value),
		.set_en(set_en), .set_val(set_val), .sp_out(sp_in));

	// ==========================================================
	// Clock and hang guard
	always #50 clk = ~clk;
	// Whole run needs well under 2000 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			summarize();
		end
	end

	// ==========================================================
	// Drivers
	function automatic tipu_region_t rg(logic [PAGE_W-1:0] s, e,
		logic [LINK_W-1:0] o, logic [NUM_LINKS-1:0] r, w);
		return tipu_region_t'{1'b1, s, e, o, r, w};
	endfunction
	task automatic cfg_go(tipu_cfg_kind_t k, logic [REG_IDX_W-1:0] i,
		tipu_region_t r, logic [STACK_W-1:0] s, logic [ADDR_W-1:0] sp);
		@(posedge clk);
		cfg_valid <= 1'b1;
		cfg <= '{k, i, r, s, 1'b0, sp};
		@(posedge clk);
		cfg_valid <= 1'b0;
	endtask
	// Outputs looked at 1 ns after the answering edge
	task automatic go(tipu_op_t op, logic [ADDR_W-1:0] pc, tg);
		@(posedge clk);
		ins_valid <= 1'b1;
		ins <= '{op, pc, tg};
		@(posedge clk);
		ins_valid <= 1'b0;
		#1;
	endtask
	task automatic da_chk(logic [ADDR_W-1:0] a, logic w, logic ok);
		@(posedge clk);
		da_valid <= 1'b1;
		da <= '{a, w};
		@(posedge clk);
		da_valid <= 1'b0;
		#1;
		`CK(da_done, 1'b1)
		`CK(da_ok, ok)
	endtask
	task automatic core_sp(logic [ADDR_W-1:0] v);
		@(posedge clk);
		set_en <= 1'b1;
		set_val <= v;
		@(posedge clk);
		set_en <= 1'b0;
	endtask
	// Fresh reset, then code regions for links 0, 2 and 1
	task automatic setup();
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		cfg_go(CFG_REGION, 0, rg(20'h00001, 20'h00001, 0, 4'h3, 4'h1), 0, 0);
		cfg_go(CFG_REGION, 1, rg(20'h00010, 20'h00011, 2, 4'h4, 4'h4), 0, 0);
		cfg_go(CFG_REGION, 2, rg(20'h00020, 20'h00020, 1, 4'h2, 4'h2), 0, 0);
		cfg_go(CFG_LINK, 2, '0, 2'h1, 0);
		cfg_go(CFG_SP, 2, '0, 0, 32'h2000_0100);
		core_sp(32'h1000_0FF0);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_data();
		setup();
		da_chk(32'h0000_1000, 1'b0, 1'b1);
		da_chk(32'h0000_1FFF, 1'b0, 1'b1);
		da_chk(32'h0000_2000, 1'b0, 1'b0);
		da_chk(32'h0000_1004, 1'b1, 1'b1);
		da_chk(32'h0001_0000, 1'b0, 1'b0);
		da_chk(32'h0005_0000, 1'b0, 1'b0);
		$display("test data done");
	endtask
	task automatic t_call();
		setup();
		go(OP_CALL, 32'h0000_1010, 32'h0002_0000);
		`CK(cur_link, 2'h1)
		da_chk(32'h0000_1000, 1'b1, 1'b0);
		da_chk(32'h0000_1000, 1'b0, 1'b1);
		go(OP_PCALL, 32'h0002_0004, 32'h0000_1000);
		go(OP_ENTRY1, 32'h0000_1000, 0);
		go(OP_ENTRY2, 32'h0000_1004, 0);
		`CK(cur_link, 2'h0)
		`CK(fault, 1'b0)
		go(OP_CALL, 32'h0000_1008, 32'h0001_0000);
		`CK(fault, 1'b1)
		go(OP_PLAIN, 32'h0000_100C, 0);
		`CK(cur_link, 2'h0)
		$display("test call done");
	endtask
	task automatic t_pcall();
		setup();
		go(OP_PCALL, 32'h0000_1000, 32'h0001_0000);
		`CK(cur_link, 2'h2)
		`CK(sp_load_valid, 1'b1)
		`CK(sp_load_value, 32'h2000_0100)
		go(OP_ENTRY1, 32'h0001_0000, 0);
		go(OP_ENTRY2, 32'h0001_0004, 0);
		`CK(fault, 1'b0)
		core_sp(32'h2000_00F0);
		go(OP_PRET, 32'h0001_0008, 32'h0000_1004);
		`CK(sp_load_value, 32'h1000_0FF0)
		go(OP_EXIT, 32'h0000_1004, 0);
		`CK(fault, 1'b0)
		go(OP_PCALL, 32'h0000_1008, 32'h0001_1000);
		`CK(sp_load_value, 32'h2000_00F0)
		go(OP_ENTRY1, 32'h0001_1000, 0);
		go(OP_ENTRY2, 32'h0001_1004, 0);
		go(OP_PRET, 32'h0001_1008, 32'h0000_100C);
		go(OP_PLAIN, 32'h0000_100C, 0);
		`CK(fault, 1'b1)
		$display("test pcall done");
	endtask
	task automatic t_pbranch();
		setup();
		go(OP_PBRANCH, 32'h0000_1000, 32'h0001_0000);
		`CK(cur_link, 2'h2)
		go(OP_ENTRY2, 32'h0001_0000, 0);
		`CK(fault, 1'b1)
		$display("test pbranch done");
	endtask
	task automatic unlock(logic [PWD_W-1:0] p, logic ok);
		@(posedge clk);
		dbg_unlock_req <= 1'b1;
		dbg_unlock_pwd <= p;
		@(posedge clk);
		dbg_unlock_req <= 1'b0;
		#1;
		`CK(dbg_unlock_done, 1'b1)
		`CK(dbg_unlock_ok, ok)
	endtask
	task automatic t_dbg();
		setup();
		@(posedge clk);
		dbg_acc_req <= 1'b1;
		#1;
		`CK(dbg_acc_ok, 1'b0)
		unlock(32'hA5A5_0002, 1'b0);
		`CK(dbg_acc_ok, 1'b0)
		unlock(32'h5A5A_0001, 1'b1);
		`CK(dbg_acc_ok, 1'b1)
		@(posedge clk);
		dbg_acc_zone <= 1'b1;
		dbg_unlock_zone <= 1'b1;
		#1;
		`CK(dbg_acc_ok, 1'b0)
		unlock(32'hA5A5_0002, 1'b1);
		`CK(dbg_acc_ok, 1'b1)
		$display("test debug done");
	endtask
	// Clock enable low must freeze the link; then a call and return
	task automatic t_hold();
		setup();
		@(posedge clk);
		ce <= 1'b0;
		go(OP_CALL, 32'h0000_1010, 32'h0002_0000);
		`CK(cur_link, 2'h0)
		@(posedge clk);
		ce <= 1'b1;
		go(OP_CALL, 32'h0000_1010, 32'h0002_0000);
		`CK(cur_link, 2'h1)
		go(OP_RET, 32'h0002_0008, 32'h0000_1014);
		`CK(cur_link, 2'h0)
		`CK(fault, 1'b0)
		$display("test hold done");
	endtask

	// ==========================================================
	// Verdict
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		t_data();
		t_call();
		t_pcall();
		t_pbranch();
		t_dbg();
		t_hold();
		summarize();
	end
endmodule

`default_nettype wire

// ==== tb/tipu_core_model.sv ====
// Core model: the stack pointer register that the unit swaps
`timescale 1ns/1ps
`default_nettype none

module tipu_core_model
	import tipu_pkg::*;
(
	input  wire logic                        clk,
	input  wire logic                        sys_rst,
	input  wire logic                        sp_load_valid,
	input  wire logic [tipu_pkg::ADDR_W-1:0] sp_load_value,
	input  wire logic                        set_en,
	input  wire logic [tipu_pkg::ADDR_W-1:0] set_val,
	output logic      [tipu_pkg::ADDR_W-1:0] sp_out
);
	import tipu_pkg::*;

	logic [ADDR_W-1:0] sp_reg;

	// ==========================================================
	// Stack pointer
	// A swap wins over a bench update, as a real core load would
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sp_reg <= '0;
		end else if (sp_load_valid) begin
			sp_reg <= sp_load_value;
		end else if (set_en) begin
			sp_reg <= set_val;
		end
	end

	// Fed back as the unit's sp_in
	assign sp_out = sp_reg;
endmodule

`default_nettype wire
